// ==== logic/event_arbiter.sv ====
// Picks the single event acted on this cycle, highest priority first.
// Assumes one-cycle event pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module event_arbiter (
  input  wire logic                  por,
  input  wire logic                  brownout,
  input  wire logic                  master_clear,
  input  wire logic                  wdt,
  input  wire logic                  rst_insn,
  input  wire logic                  stk_full,
  input  wire logic                  stk_unf,
  input  wire logic                  int_wake,
  input  wire logic                  sw_rearm,
  output reset_cause_pkg::event_t    ev
);
  always_comb begin
    if (por)           ev = reset_cause_pkg::EV_POR;
    else if (brownout) ev = reset_cause_pkg::EV_BROWNOUT;
    else if (master_clear) ev = reset_cause_pkg::EV_MASTER_CLEAR;
    else if (wdt)      ev = reset_cause_pkg::EV_WDT;
    else if (stk_full) ev = reset_cause_pkg::EV_STKF;
    else if (stk_unf)  ev = reset_cause_pkg::EV_STKU;
    else if (rst_insn) ev = reset_cause_pkg::EV_RSTI;
    else if (int_wake) ev = reset_cause_pkg::EV_INT;
    else if (sw_rearm) ev = reset_cause_pkg::EV_SWCLR;
    else               ev = reset_cause_pkg::EV_NONE;
  end
endmodule : event_arbiter
`default_nettype wire

// ==== logic/reset_cause_consts.svh ====
// Constants for the reset cause recorder: addresses, step sizes, stack depth, brown-out config value.
// Assumes inclusion by bare name from files under logic/.
// How it works
// - Only cause flags and stack state forced.
// - Watchdog wake resumes, no reset applied.
// - Power-on restarts at zero, sets three flags.
// - Reset instruction clears only its flag.
// - Brown-out sets three flags, clears brown-out flag.
// - Master clear in run mode sets TO.
// - Master clear in idle sets TO, clears PD.
// - Watchdog in run resets, clears TO.
// - Master clear at full power leaves flags alone, still resets.
// - Stack full resets when enabled, sets flag.
// - Stack underflow resets when enabled, sets flag.
// - Underflow without enable only sets flag.
// - Watchdog in sleep resumes, clears timeout, powerdown.
// - Interrupt wake clears PD, resumes next address.
// - Enabled interrupt wake loads matching vector.
// - Vectored wake pushes PC, advances pointer, holds it at 1F.
// - Interrupt wake leaves a source flag set.
// - Software brown-out enable reset value rule.
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH
`define RESTART_ADDR   21'h000000
`define HIGH_VECTOR    21'h000008
`define LOW_VECTOR     21'h000018
`define NEXT_INSN_STEP 21'h000002
`define STACK_STEP     5'h01
`define STACK_DEPTH    5'h1F
`define BROWNOUT_CFG_SW 2'h1
`endif

// ==== logic/reset_cause_pkg.sv ====
// Types shared by the reset cause recorder.
// Assumes nothing of its surroundings.
package reset_cause_pkg;
  typedef enum logic [1:0] {
    PM_FULL = 2'h0,
    PM_RUN  = 2'h1,
    PM_IDLE = 2'h2
  } power_mode_t;

  typedef struct packed {
    logic reset_instruction_flag;
    logic watchdog_timeout_flag;
    logic powerdown_flag;
    logic poweron_flag;
    logic brownout_flag;
    logic stack_full_flag;
    logic stack_underflow_flag;
  } cause_flags_t;

  typedef enum logic [3:0] {
    EV_NONE  = 4'h0,
    EV_POR   = 4'h1,
    EV_RSTI  = 4'h2,
    EV_BROWNOUT     = 4'h3,
    EV_MASTER_CLEAR = 4'h4,
    EV_WDT   = 4'h5,
    EV_STKF  = 4'h6,
    EV_STKU  = 4'h7,
    EV_INT   = 4'h8,
    EV_SWCLR = 4'h9
  } event_t;
endpackage : reset_cause_pkg

// ==== logic/reset_cause_recorder.sv ====
// Reset cause recorder: updates cause flags, restart address and stack push.
// Assumes event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_consts.svh"
module reset_cause_recorder #(
  parameter int PC_W = 21,
  parameter int SP_W = 5
) (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         por_event,
  input  wire logic                         brownout_event,
  input  wire logic                         master_clear_pin,
  input  wire logic                         wdt_timeout,
  input  wire logic                         reset_insn,
  input  wire logic                         stack_full_event,
  input  wire logic                         stack_underflow_event,
  input  wire logic                         int_wake,
  input  wire logic                         int_high_priority,
  input  wire reset_cause_pkg::power_mode_t power_mode,
  input  wire logic                         stack_error_reset_enable,
  input  wire logic                         high_priority_global_enable,
  input  wire logic                         low_priority_global_enable,
  input  wire logic [1:0]                   brownout_config_field,
  input  wire logic                         sbor_wr,
  input  wire logic                         sbor_wdata,
  input  wire logic                         flags_wr,
  input  wire reset_cause_pkg::cause_flags_t flags_wdata,
  input  wire logic [PC_W-1:0]              current_pc,
  output reset_cause_pkg::cause_flags_t     reset_cause_register,
  output logic                              software_brownout_enable,
  output logic [PC_W-1:0]                   next_pc,
  output logic                              pc_load,
  output logic                              device_reset,
  output logic                              tos_push,
  output logic [PC_W-1:0]                   top_of_stack,
  output logic [SP_W-1:0]                   stack_pointer_register,
  output logic                              wake_source_flag
);
  // ------------------------------------------------------------------
  // Event selection
  // ------------------------------------------------------------------
  reset_cause_pkg::event_t ev;
  event_arbiter u_arb (
    .por      (por_event),
    .brownout     (brownout_event),
    .master_clear (master_clear_pin),
    .wdt      (wdt_timeout),
    .rst_insn (reset_insn),
    .stk_full (stack_full_event),
    .stk_unf  (stack_underflow_event),
    .int_wake (int_wake),
    .sw_rearm (flags_wr),
    .ev       (ev)
  );

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  reset_cause_pkg::cause_flags_t flags_q, flags_d;
  logic              sbor_q, sbor_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic              load_q, load_d;
  logic              rst_q, rst_d;
  logic              push_q, push_d;
  logic [PC_W-1:0]   tos_q, tos_d;
  logic [SP_W-1:0]   sp_q, sp_d;
  logic              wsrc_q, wsrc_d;
  logic [PC_W-1:0]   pc_next_insn;
  logic              sleeping;

  assign pc_next_insn = current_pc + PC_W'(`NEXT_INSN_STEP);
  assign sleeping     = (power_mode == reset_cause_pkg::PM_IDLE);

  // ------------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------------
  always_comb begin
    flags_d = flags_q;
    sbor_d  = sbor_q;
    pc_d    = pc_q;
    load_d  = 1'b0;
    rst_d   = 1'b0;
    push_d  = 1'b0;
    tos_d   = tos_q;
    sp_d    = sp_q;
    wsrc_d  = wsrc_q;
    // Other registers outside this block are neither cleared nor touched
    case (ev)
      reset_cause_pkg::EV_POR: begin
        flags_d = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        pc_d    = PC_W'(`RESTART_ADDR);
        load_d  = 1'b1;
        rst_d   = 1'b1;
        sp_d    = '0;
        sbor_d  = 1'b1;
        wsrc_d  = 1'b0;
      end
      reset_cause_pkg::EV_BROWNOUT: begin
        flags_d.reset_instruction_flag = 1'b1;
        flags_d.watchdog_timeout_flag  = 1'b1;
        flags_d.powerdown_flag         = 1'b1;
        flags_d.brownout_flag          = 1'b0;
        pc_d   = PC_W'(`RESTART_ADDR);
        load_d = 1'b1;
        rst_d  = 1'b1;
        sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
      end
      reset_cause_pkg::EV_MASTER_CLEAR: begin
        if (power_mode == reset_cause_pkg::PM_RUN) begin
          flags_d.watchdog_timeout_flag = 1'b1;
        end else if (sleeping) begin
          flags_d.watchdog_timeout_flag = 1'b1;
          flags_d.powerdown_flag        = 1'b0;
        end
        // Full power leaves flags alone
        pc_d   = PC_W'(`RESTART_ADDR);
        load_d = 1'b1;
        rst_d  = 1'b1;
        sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
      end
      reset_cause_pkg::EV_WDT: begin
        flags_d.watchdog_timeout_flag = 1'b0;
        load_d = 1'b1;
        if (sleeping) begin
          flags_d.powerdown_flag = 1'b0;
          pc_d = pc_next_insn;
        end else begin
          pc_d   = PC_W'(`RESTART_ADDR);
          rst_d  = 1'b1;
          sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
        end
      end
      reset_cause_pkg::EV_STKF: begin
        if (stack_error_reset_enable) begin
          flags_d.stack_full_flag = 1'b1;
          pc_d   = PC_W'(`RESTART_ADDR);
          load_d = 1'b1;
          rst_d  = 1'b1;
          sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
        end else begin
          flags_d.stack_full_flag = 1'b1;
        end
      end
      reset_cause_pkg::EV_STKU: begin
        flags_d.stack_underflow_flag = 1'b1;
        if (stack_error_reset_enable) begin
          pc_d   = PC_W'(`RESTART_ADDR);
          load_d = 1'b1;
          rst_d  = 1'b1;
          sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
        end
      end
      reset_cause_pkg::EV_RSTI: begin
        flags_d.reset_instruction_flag = 1'b0;
        pc_d   = PC_W'(`RESTART_ADDR);
        load_d = 1'b1;
        rst_d  = 1'b1;
        sbor_d = (brownout_config_field == `BROWNOUT_CFG_SW) && sbor_q;
      end
      reset_cause_pkg::EV_INT: begin
        if (power_mode != reset_cause_pkg::PM_FULL) begin
          flags_d.powerdown_flag = 1'b0;
          wsrc_d = 1'b1;
          load_d = 1'b1;
          if (int_high_priority ? high_priority_global_enable
                                : low_priority_global_enable) begin
            pc_d = int_high_priority ? PC_W'(`HIGH_VECTOR)
                                     : PC_W'(`LOW_VECTOR);
            tos_d  = current_pc;
            push_d = 1'b1;
            if (sp_q != SP_W'(`STACK_DEPTH)) begin
              sp_d = sp_q + SP_W'(`STACK_STEP);
            end
          end else begin
            pc_d = pc_next_insn;
          end
        end
      end
      reset_cause_pkg::EV_SWCLR: begin
        flags_d = flags_wdata;
        wsrc_d  = 1'b0;
      end
      default: begin
        flags_d = flags_q;
      end
    endcase
    if (sbor_wr && ev == reset_cause_pkg::EV_NONE) begin
      sbor_d = sbor_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      sbor_q  <= 1'b1;
      pc_q    <= PC_W'(`RESTART_ADDR);
      load_q  <= 1'b0;
      rst_q   <= 1'b0;
      push_q  <= 1'b0;
      tos_q   <= '0;
      sp_q    <= '0;
      wsrc_q  <= 1'b0;
    end else if (ce) begin
      flags_q <= flags_d;
      sbor_q  <= sbor_d;
      pc_q    <= pc_d;
      load_q  <= load_d;
      rst_q   <= rst_d;
      push_q  <= push_d;
      tos_q   <= tos_d;
      sp_q    <= sp_d;
      wsrc_q  <= wsrc_d;
    end
  end

  assign reset_cause_register     = flags_q;
  assign software_brownout_enable = sbor_q;
  assign next_pc                  = pc_q;
  assign pc_load                  = load_q;
  assign device_reset             = rst_q;
  assign tos_push                 = push_q;
  assign top_of_stack             = tos_q;
  assign stack_pointer_register   = sp_q;
  assign wake_source_flag         = wsrc_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_por;
    ce && ev == reset_cause_pkg::EV_POR;
  endsequence

  a_por_flags: assert property (@(posedge clk) disable iff (srst)
    s_por |=> flags_q == '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0} && pc_q == '0)
    else $error("power-on flags wrong");
  a_rsti_only: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_RSTI |=> !flags_q.reset_instruction_flag
      && flags_q[5:0] == $past(flags_q[5:0]))
    else $error("reset instruction changed other flags");
  a_brownout_flags: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_BROWNOUT |=> !flags_q.brownout_flag
      && flags_q.powerdown_flag && flags_q.poweron_flag == $past(flags_q.poweron_flag))
    else $error("brown-out flags wrong");
  a_clear_full: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_MASTER_CLEAR && power_mode == reset_cause_pkg::PM_FULL
      |=> $stable(flags_q) && device_reset)
    else $error("full-power master clear altered flags");
  a_wdt_sleep: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_WDT && sleeping
      |=> !device_reset && !flags_q.watchdog_timeout_flag && !flags_q.powerdown_flag)
    else $error("watchdog wake wrong");
  a_wdt_run: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_WDT && !sleeping |=> device_reset && pc_q == '0)
    else $error("watchdog reset missing");
  a_unf_noreset: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_STKU && !stack_error_reset_enable
      |=> !device_reset && flags_q.stack_underflow_flag)
    else $error("underflow without enable wrong");
  a_vector_push: assert property (@(posedge clk) disable iff (srst)
    tos_push && $past(ce) |-> sp_q == $past(sp_q) + SP_W'(`STACK_STEP)
      || sp_q == SP_W'(`STACK_DEPTH))
    else $error("push without pointer advance");
  a_vector_addr: assert property (@(posedge clk) disable iff (srst)
    tos_push |-> pc_q == PC_W'(`HIGH_VECTOR) || pc_q == PC_W'(`LOW_VECTOR))
    else $error("vectored wake address wrong");

  sequence s_wake_int;
    ce && ev == reset_cause_pkg::EV_INT && power_mode != reset_cause_pkg::PM_FULL;
  endsequence

  sequence s_reset_taken;
    ce && (ev == reset_cause_pkg::EV_POR || ev == reset_cause_pkg::EV_BROWNOUT
      || ev == reset_cause_pkg::EV_MASTER_CLEAR || ev == reset_cause_pkg::EV_RSTI);
  endsequence

  a_clear_run_mode: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_MASTER_CLEAR && power_mode == reset_cause_pkg::PM_RUN
      |=> flags_q.watchdog_timeout_flag && flags_q.powerdown_flag == $past(flags_q.powerdown_flag))
    else $error("run-mode master clear flags wrong");
  a_clear_sleep: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_MASTER_CLEAR && sleeping
      |=> flags_q.watchdog_timeout_flag && !flags_q.powerdown_flag && device_reset)
    else $error("sleep master clear flags wrong");
  a_full_reset: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_STKF && stack_error_reset_enable
      |=> flags_q.stack_full_flag && device_reset && pc_q == '0)
    else $error("stack full reset wrong");
  a_unf_reset: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_STKU && stack_error_reset_enable
      |=> flags_q.stack_underflow_flag && device_reset && pc_q == '0)
    else $error("stack underflow reset wrong");
  a_int_wake: assert property (@(posedge clk) disable iff (srst)
    s_wake_int |=> !flags_q.powerdown_flag && pc_load && !device_reset)
    else $error("interrupt wake wrong");
  a_wake_source: assert property (@(posedge clk) disable iff (srst)
    s_wake_int |=> wake_source_flag)
    else $error("wake source flag missing");
  a_wdt_resume: assert property (@(posedge clk) disable iff (srst)
    ce && ev == reset_cause_pkg::EV_WDT && sleeping |=> pc_q == $past(pc_next_insn))
    else $error("watchdog wake address wrong");
  a_reset_restart: assert property (@(posedge clk) disable iff (srst)
    s_reset_taken |=> device_reset && pc_load && pc_q == '0)
    else $error("reset restart missing");
  a_sbor_poweron: assert property (@(posedge clk) disable iff (srst)
    s_por |=> software_brownout_enable)
    else $error("software brown-out enable not set");
  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(flags_q) && $stable(pc_q) && $stable(sp_q))
    else $error("state moved while clock enable low");
endmodule : reset_cause_recorder
`default_nettype wire

// ==== tb/reset_cause_recorder_tb.sv ====
// Self-checking bench for the reset cause recorder: directed corners, then seeded random events.
// Assumes the package and both design modules compiled first; 100 MHz clk, srst active high.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module reset_cause_recorder_tb;
  localparam int LIMIT = 20000;
  logic                          clk = 1'b0;
  logic                          srst = 1'b1;
  logic                          ce = 1'b1;
  logic [8:0]                    evs = '0;
  logic                          hi = 1'b0;
  logic [1:0]                    mode = 2'h0;
  logic                          en = 1'b0;
  logic [1:0]                    gie = 2'h0;
  logic [1:0]                    cfg = 2'h1;
  logic                          swr = 1'b0;
  logic                          swd = 1'b0;
  logic [6:0]                    wd = '0;
  logic [20:0]                   cur = '0;
  reset_cause_pkg::cause_flags_t flags;
  logic                          sbor, load, rst, push, wsrc;
  logic [20:0]                   pc, tos;
  logic [4:0]                    sp;
  logic [6:0]                    e_flags;
  logic                          e_sbor, e_load, e_rst, e_push, e_wsrc;
  logic [20:0]                   e_pc, e_tos;
  logic [4:0]                    e_sp;
  int                            fails = 0;
  int                            num_checks = 0;
  int                            cycles = 0;

  reset_cause_recorder DUT (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .por_event(evs[0]),
    .brownout_event(evs[1]),
    .master_clear_pin(evs[2]),
    .wdt_timeout(evs[3]),
    .stack_full_event(evs[4]),
    .stack_underflow_event(evs[5]),
    .reset_insn(evs[6]),
    .int_wake(evs[7]),
    .int_high_priority(hi),
    .power_mode(reset_cause_pkg::power_mode_t'(mode)),
    .stack_error_reset_enable(en),
    .high_priority_global_enable(gie[1]),
    .low_priority_global_enable(gie[0]),
    .brownout_config_field(cfg),
    .sbor_wr(swr),
    .sbor_wdata(swd),
    .flags_wr(evs[8]),
    .flags_wdata(wd),
    .current_pc(cur),
    .reset_cause_register(flags),
    .software_brownout_enable(sbor),
    .next_pc(pc),
    .pc_load(load),
    .device_reset(rst),
    .tos_push(push),
    .top_of_stack(tos),
    .stack_pointer_register(sp),
    .wake_source_flag(wsrc)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  // Flags MSB first: instruction, timeout, powerdown, power-on, brown-out, full, underflow
  function automatic logic [6:0] flags_after(input logic [6:0] f, input int k);
    case (k)
      1: return 7'h70;
      2: return (f | 7'h70) & 7'h7B;
      3: return (mode == 2'h1) ? f | 7'h20 : (mode == 2'h2) ? (f | 7'h20) & 7'h6F : f;
      4: return f & ((mode == 2'h2) ? 7'h4F : 7'h5F);
      5: return f | 7'h02;
      6: return f | 7'h01;
      7: return f & 7'h3F;
      8: return (mode != 2'h0) ? f & 7'h6F : f;
      9: return wd;
      default: return f;
    endcase
  endfunction : flags_after

  task automatic reset_model();
    e_flags = 7'h70;
    e_sbor = 1'b1;
    e_pc = '0;
    e_tos = '0;
    e_sp = '0;
    {e_load, e_rst, e_push, e_wsrc} = '0;
  endtask : reset_model

  // Drives one cycle at the falling edge, models the answer, checks it a cycle later
  task automatic step(input logic [8:0] ev);
    int   k;
    logic vec;
    k = 0;
    for (int i = 8; i >= 0; i--) begin
      if (ev[i]) k = i + 1;
    end
    vec = (hi ? gie[1] : gie[0]) && k == 8 && mode != 2'h0;
    evs = ev;
    if (ce) begin
      e_rst = k inside {1, 2, 3, 7} || (k == 4 && mode != 2'h2) || (k inside {5, 6} && en);
      e_load = e_rst || k == 4 || (k == 8 && mode != 2'h0);
      e_push = vec;
      if (e_rst) e_pc = '0;
      else if (vec) e_pc = hi ? 21'h8 : 21'h18;
      else if (e_load) e_pc = cur + 21'h2;
      if (vec) e_tos = cur;
      if (vec && e_sp != 5'h1F) e_sp = e_sp + 5'h1;
      if (k == 1) e_sp = '0;
      if (k == 1) e_sbor = 1'b1;
      else if (e_rst) e_sbor = cfg == 2'h1 && e_sbor;
      else if (k == 0 && swr) e_sbor = swd;
      if (k == 8 && mode != 2'h0) e_wsrc = 1'b1;
      if (k inside {1, 9}) e_wsrc = 1'b0;
      e_flags = flags_after(e_flags, k);
    end
    @(posedge clk);
    @(negedge clk);
    `CHK(flags, e_flags)
    `CHK(pc, e_pc)
    `CHK({load, rst, push}, {e_load, e_rst, e_push})
    `CHK(tos, e_tos)
    `CHK(sp, e_sp)
    `CHK(wsrc, e_wsrc)
    `CHK(sbor, e_sbor)
  endtask : step

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    void'($urandom(32'hC8CB));
    repeat (16) @(negedge clk);
    srst = 1'b0;
    reset_model();
    step(9'h000);
    step(9'h001);
    `CHK(flags, 7'h70)
    wd = 7'h7F;
    step(9'h100);
    step(9'h040);
    `CHK(flags, 7'h3F)
    wd = 7'h0B;
    step(9'h100);
    step(9'h002);
    `CHK(flags, 7'h7B)
    mode = 2'h1;
    step(9'h004);
    `CHK(flags.watchdog_timeout_flag, 1'b1)
    mode = 2'h2;
    cur = 21'h1234;
    step(9'h008);
    `CHK({rst, pc}, {1'b0, 21'h1236})
    step(9'h020);
    `CHK(rst, 1'b0)
    en = 1'b1;
    step(9'h010);
    `CHK({rst, flags.stack_full_flag}, 2'h3)
    gie = 2'h2;
    hi = 1'b1;
    step(9'h080);
    `CHK({push, pc, tos}, {1'b1, 21'h8, 21'h1234})
    cfg = 2'h0;
    step(9'h004);
    `CHK(sbor, 1'b0)
    ce = 1'b0;
    step(9'h001);
    ce = 1'b1;
    $display("test directed done");
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    reset_model();
    step(9'h080);
    $display("test mid-run reset done");
    repeat (3000) begin
      ce = $urandom_range(15) != 0;
      mode = 2'($urandom_range(2));
      en = 1'($urandom);
      gie = 2'($urandom);
      hi = 1'($urandom);
      cfg = 2'($urandom);
      swr = 1'($urandom);
      swd = 1'($urandom);
      wd = 7'($urandom);
      cur = 21'($urandom);
      step(9'(1 << $urandom_range(9)) | (($urandom_range(7) == 0) ? 9'($urandom) : 9'h0));
    end
    $display("test random done");
    stop_test();
  end
endmodule : reset_cause_recorder_tb
`default_nettype wire
